// ---- tb/cpu_model.sv ----
// cpu side model: command strobes and byte reads of the flash array
module cpu_model
  import flash_flags_pkg::*;
(
  // clock
  input wire logic clk_i,
  // command side
  output logic cmd_valid_o,
  output logic [2:0] cmd_kind_o,
  output logic [15:0] cmd_addr_o,
  output logic [7:0] cmd_data_o,
  output logic [7:0] cmd_old_o,
  input wire logic cmd_accept_i,
  // read side
  output logic rd_o,
  output logic [15:0] rd_addr_o,
  output logic [7:0] array_data_o,
  input wire logic [7:0] rd_data_i,
  input wire logic rd_valid_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd_valid_o = 1'b0;
    cmd_kind_o = 3'h0;
    cmd_addr_o = 16'h0000;
    cmd_data_o = 8'h00;
    cmd_old_o = 8'h00;
    rd_o = 1'b0;
    rd_addr_o = 16'h0000;
    array_data_o = 8'h00;
  end
  // sector enables are written by the bench before any command
  task automatic cmd(input logic [2:0] k, input logic [15:0] a, input logic [7:0] d,
                     input logic [7:0] o, output logic acc);
    @(posedge clk_i);
    cmd_valid_o <= 1'b1;
    cmd_kind_o <= k;
    cmd_addr_o <= a;
    cmd_data_o <= d;
    cmd_old_o <= o;
    // the answer is taken at the same edge that takes the command
    @(posedge clk_i);
    acc = cmd_accept_i;
    cmd_valid_o <= 1'b0;
  endtask : cmd
  task automatic rd(input logic [15:0] a, input logic [7:0] arr, output logic [7:0] q);
    @(posedge clk_i);
    rd_o <= 1'b1;
    rd_addr_o <= a;
    array_data_o <= arr;
    @(posedge clk_i);
    rd_o <= 1'b0;
    // released data lines must not keep showing the last byte
    array_data_o <= ~arr;
    @(negedge clk_i);
    q = rd_valid_i ? rd_data_i : 8'hxx;
  endtask : rd
endmodule : cpu_model

// ---- tb/tb.sv ----
// self-checking bench for the flash status-flag block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_flags_pkg::*;
  logic fault = 1'b0;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, wb_q;
  logic ack, cv, ca, rdv, rd, busy;
  logic [2:0] ck;
  logic [15:0] caddr, raddr;
  logic [7:0] cd, co, arr, rq, a, b;
  logic acc;
  int err_total = 0, n_compared = 0, cyc_cnt = 0;
  always #5 clk_i = ~clk_i;
  flash_algorithm_status_flags DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .cmd_valid_i(cv), .cmd_kind_i(ck),
    .cmd_addr_i(caddr), .cmd_data_i(cd), .cmd_old_i(co), .cmd_accept_o(ca),
    .erase_fault_i(fault), .rd_i(rd), .rd_addr_i(raddr), .array_data_i(arr),
    .rd_data_o(rq), .rd_valid_o(rdv), .busy_o(busy));
  cpu_model cpu (.clk_i(clk_i), .cmd_valid_o(cv), .cmd_kind_o(ck), .cmd_addr_o(caddr),
    .cmd_data_o(cd), .cmd_old_o(co), .cmd_accept_i(ca), .rd_o(rd), .rd_addr_o(raddr),
    .array_data_o(arr), .rd_data_i(rq), .rd_valid_i(rdv));
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [3:0] ad, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    wb_q = rdat;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic wait_idle();
    for (int i = 0; i < 5000 && busy !== 1'b0; i++) @(posedge clk_i);
  endtask : wait_idle
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt > 40000) begin
      err_total++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, ADR_STATUS, 0); chk("ready idle", wb_q, 32'h1);
    wb(0, 4'h8, 0); chk("unmapped", wb_q, 32'h0);
    wb(1, ADR_SWEN, 32'hf); wb(0, ADR_SWEN, 0); chk("swen", wb_q, 32'hf);
    $display("test registers done");
    cpu.cmd(CMD_PROG, 16'h1800, 8'h5a, 8'hff, acc); chk("prog acc", acc, 1);
    cpu.rd(16'h1800, 8'h00, a); chk("prog flags", a & 8'hbf, 8'h80);
    cpu.rd(16'h1800, 8'h00, b); chk("prog tog", a[6] ^ b[6], 1);
    cpu.rd(16'h8000, 8'h3c, a); chk("other bank", a, 8'h3c);
    wb(0, ADR_STATUS, 0); chk("ready busy", wb_q[0], 0);
    wait_idle(); cpu.rd(16'h1800, 8'h5a, a); chk("prog done", a, 8'h5a);
    $display("test program done");
    cpu.cmd(CMD_SECT, 16'h2000, 8'h00, 8'h00, acc); chk("sect acc", acc, 1);
    cpu.rd(16'h2000, 8'h00, a); chk("wait flags", a & 8'hbb, 8'h00);
    cpu.rd(16'h2000, 8'h00, b); chk("wait tog", {a[6], a[2]} ^ {b[6], b[2]}, 2'b11);
    cpu.cmd(CMD_PROG, 16'h2000, 8'h00, 8'hff, acc); chk("prog refused", acc, 0);
    repeat (3100) @(posedge clk_i);
    cpu.rd(16'h2000, 8'h00, a); chk("erase win", a & 8'hbb, 8'h08);
    cpu.cmd(CMD_SUSP, 16'h2000, 8'h00, 8'h00, acc); chk("susp acc", acc, 1);
    cpu.rd(16'h2000, 8'h00, a); chk("susp flags", a & 8'hfb, 8'h08);
    cpu.rd(16'h2000, 8'h00, b); chk("susp tog2", a[2] ^ b[2], 1);
    cpu.rd(16'h8000, 8'ha5, a); chk("susp other", a, 8'ha5);
    cpu.cmd(CMD_RESUME, 16'h2000, 8'h00, 8'h00, acc); chk("res acc", acc, 1);
    cpu.rd(16'h2000, 8'h00, a); cpu.rd(16'h2000, 8'h00, b);
    chk("res tog", a[6] ^ b[6], 1);
    chk("res flags", b & 8'hbb, 8'h08);
    wait_idle(); cpu.rd(16'h2000, 8'hff, a); chk("erase done", a, 8'hff);
    $display("test erase done");
    cpu.cmd(CMD_PROG, 16'h1800, 8'h01, 8'h00, acc); chk("bad acc", acc, 1);
    repeat (4100) @(posedge clk_i);
    cpu.rd(16'h1800, 8'h00, a); chk("fail flags", a & 8'hbf, 8'ha0);
    wb(0, ADR_STATUS, 0); chk("fail stat", wb_q[1:0], 2'b10);
    cpu.cmd(CMD_PROG, 16'h1800, 8'h01, 8'hff, acc); chk("fail refuse", acc, 0);
    cpu.cmd(CMD_RESET, 16'h1800, 8'h00, 8'h00, acc); chk("reset acc", acc, 1);
    wait_idle(); cpu.rd(16'h1800, 8'h77, a); chk("reset read", a, 8'h77);
    $display("test failure done");
    cpu.cmd(CMD_CHIP, 16'h1800, 8'h00, 8'h00, acc); chk("chip acc", acc, 1);
    @(posedge clk_i); fault <= 1'b1;
    @(posedge clk_i); fault <= 1'b0;
    cpu.rd(16'h1800, 8'h00, a); chk("erase fail flags", a & 8'hbb, 8'h28);
    cpu.cmd(CMD_RESET, 16'h1800, 8'h00, 8'h00, acc); chk("reset acc2", acc, 1);
    wait_idle(); cpu.rd(16'h1800, 8'h66, a); chk("reset read2", a, 8'h66);
    $display("test erase failure done");
    tally_and_finish();
  end
endmodule : tb

// ---- verilog/flash_algorithm_status_flags.sv ----
// status-flag readout and sequencing of the flash program/erase algorithm
// Notes on behaviour
// - status byte flags at bits 7,6,5,3,2
// - flags only on commanded bank, operated sector
// - algorithm end returns to read/reset state
// - program: inverted bit 7, toggle, others zero
// - after program, bit 7 is stored data
// - erase: poll 0, toggle, window 1, toggle2
// - erase wait: poll 0, toggles, window 0
// - suspended: toggle stops at 0, toggle2 runs
// - resume: toggle restarts, window stays 1
// - suspended: erasing sector poll 0, others data
// - failure: program inverted bit, erase zero
// - poll plus toggle reveal suspend and sector
// - status replaces array read until completion
// - flags show extra sector code accepted
// - ready bit in flash status register
// - toggle inverts on each status read except while suspended
// - time overrun sets timeout, needs reset
// - window 0 during wait, 1 after
// - erasing ignores all but suspend command
module flash_algorithm_status_flags
  import flash_flags_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone register slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // decoded commands from the sequence decoder
  input wire logic cmd_valid_i,
  input wire logic [2:0] cmd_kind_i,
  input wire logic [15:0] cmd_addr_i,
  input wire logic [7:0] cmd_data_i,
  input wire logic [7:0] cmd_old_i,
  output logic cmd_accept_o,
  // array verify fault during erase
  input wire logic erase_fault_i,
  // cpu read port
  input wire logic rd_i,
  input wire logic [15:0] rd_addr_i,
  input wire logic [7:0] array_data_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  // algorithm status
  output logic busy_o
);

  state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [7:0] last_q, last_d;
  logic [1:0] op_sec_q, op_sec_d;
  logic [3:0] erase_set_q, erase_set_d;
  logic conflict_q, conflict_d;
  logic fail_erase_q, fail_erase_d;
  logic tog_q, tog_d;
  logic tog2_q, tog2_d;
  logic [7:0] rd_data_q, rd_data_d;
  logic rd_valid_q;
  logic [3:0] swen_q, swen_d;
  logic [31:0] wb_dat_q, wb_dat_d;
  logic ack_q;
  cmd_t kind;
  logic [1:0] cmd_sec;
  logic [1:0] rd_sec;
  logic bank_hit;
  logic in_erase_sec;
  logic status_hit;
  logic prog_hit;
  logic accept;
  logic last7;

  assign kind = cmd_t'(cmd_kind_i);
  assign cmd_sec = sector_of(cmd_addr_i);
  assign rd_sec = sector_of(rd_addr_i);
  assign last7 = last_q[POS_POLL];
  // only the bank that took the command shows flags
  assign bank_hit = rd_sec[1] == op_sec_q[1];
  assign in_erase_sec = erase_set_q[rd_sec];
  assign prog_hit = rd_sec == op_sec_q;

  // sequencer
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    last_d = last_q;
    op_sec_d = op_sec_q;
    erase_set_d = erase_set_q;
    conflict_d = conflict_q;
    fail_erase_d = fail_erase_q;
    accept = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (cmd_valid_i && kind == CMD_PROG && swen_q[cmd_sec]) begin
          accept = 1'b1;
          last_d = cmd_data_i;
          op_sec_d = cmd_sec;
          conflict_d = |(cmd_data_i & ~cmd_old_i);
          // a 1 over a stored 0 never verifies and runs into the limit
          cnt_d = conflict_d ? LIMIT_CYC : PROG_CYC;
          state_d = ST_PROG;
        end else if (cmd_valid_i && kind == CMD_CHIP && &swen_q) begin
          accept = 1'b1;
          op_sec_d = cmd_sec;
          erase_set_d = 4'hf;
          cnt_d = ERASE_CYC;
          state_d = ST_ERASE;
        end else if (cmd_valid_i && kind == CMD_SECT && swen_q[cmd_sec]) begin
          accept = 1'b1;
          op_sec_d = cmd_sec;
          erase_set_d = 4'h1 << cmd_sec;
          cnt_d = WAIT_CYC;
          state_d = ST_WAIT;
        end
      end
      ST_PROG: begin
        cnt_d = cnt_q - 1'b1;
        if (cnt_q == 1'b1) begin
          fail_erase_d = 1'b0;
          state_d = conflict_q ? ST_FAIL : ST_IDLE;
        end
      end
      ST_WAIT: begin
        cnt_d = cnt_q - 1'b1;
        // extra sector codes only count inside the wait period
        if (cmd_valid_i && kind == CMD_SECT && swen_q[cmd_sec]
            && cmd_sec[1] == op_sec_q[1]) begin
          accept = 1'b1;
          erase_set_d = erase_set_q | (4'h1 << cmd_sec);
          cnt_d = WAIT_CYC;
        end else if (cnt_q == 1'b1) begin
          cnt_d = ERASE_CYC;
          state_d = ST_ERASE;
        end
      end
      ST_ERASE: begin
        cnt_d = cnt_q - 1'b1;
        if (cmd_valid_i && kind == CMD_SUSP) begin
          accept = 1'b1;
          cnt_d = cnt_q;
          state_d = ST_SUSP;
        end else if (erase_fault_i) begin
          fail_erase_d = 1'b1;
          state_d = ST_FAIL;
        end else if (cnt_q == 1'b1) begin
          erase_set_d = 4'h0;
          state_d = ST_IDLE;
        end
      end
      ST_SUSP: begin
        if (cmd_valid_i && kind == CMD_RESUME) begin
          accept = 1'b1;
          state_d = ST_ERASE;
        end
      end
      ST_FAIL: begin
        // the locked state holds until software issues reset
        if (cmd_valid_i && kind == CMD_RESET) begin
          accept = 1'b1;
          erase_set_d = 4'h0;
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      last_q <= 8'h00;
      op_sec_q <= 2'h0;
      erase_set_q <= 4'h0;
      conflict_q <= 1'b0;
      fail_erase_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      last_q <= last_d;
      op_sec_q <= op_sec_d;
      erase_set_q <= erase_set_d;
      conflict_q <= conflict_d;
      fail_erase_q <= fail_erase_d;
    end
  end

  assign cmd_accept_o = accept;
  assign busy_o = state_q != ST_IDLE;

  // read path: a status byte stands in for array data
  always_comb begin
    rd_data_d = rd_data_q;
    tog_d = tog_q;
    tog2_d = tog2_q;
    status_hit = 1'b0;
    if (rd_i) begin
      rd_data_d = array_data_i;
      case (state_q)
        ST_PROG: begin
          status_hit = bank_hit && prog_hit;
          if (status_hit) begin
            rd_data_d[POS_POLL] = ~last_q[POS_POLL];
            rd_data_d[POS_TOG] = tog_q;
            rd_data_d[POS_TMO] = 1'b0;
            rd_data_d[POS_WIN] = 1'b0;
            rd_data_d[POS_TOG2] = 1'b0;
          end
        end
        ST_WAIT, ST_ERASE, ST_SUSP: begin
          status_hit = bank_hit && in_erase_sec;
          if (status_hit) begin
            rd_data_d[POS_POLL] = 1'b0;
            rd_data_d[POS_TOG] = (state_q == ST_SUSP) ? 1'b0 : tog_q;
            rd_data_d[POS_TMO] = 1'b0;
            rd_data_d[POS_WIN] = state_q != ST_WAIT;
            rd_data_d[POS_TOG2] = tog2_q;
          end
        end
        ST_FAIL: begin
          status_hit = bank_hit && (fail_erase_q ? in_erase_sec : prog_hit);
          if (status_hit) begin
            rd_data_d[POS_POLL] = fail_erase_q ? 1'b0 : ~last_q[POS_POLL];
            rd_data_d[POS_TOG] = tog_q;
            rd_data_d[POS_TMO] = 1'b1;
            rd_data_d[POS_WIN] = fail_erase_q;
            rd_data_d[POS_TOG2] = fail_erase_q ? tog2_q : 1'b0;
          end
        end
        default: begin
          status_hit = 1'b0;
        end
      endcase
      // toggle rests at 0 while suspended so resume restarts from 0
      if (status_hit && state_q != ST_SUSP) begin
        tog_d = ~tog_q;
      end
      if (status_hit && (state_q != ST_PROG) && !(state_q == ST_FAIL && !fail_erase_q)) begin
        tog2_d = ~tog2_q;
      end
    end
    if (state_q == ST_SUSP || state_q == ST_IDLE) begin
      tog_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
      tog_q <= 1'b0;
      tog2_q <= 1'b0;
    end else begin
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_i;
      tog_q <= tog_d;
      tog2_q <= tog2_d;
    end
  end

  assign rd_data_o = rd_data_q;
  assign rd_valid_o = rd_valid_q;

  // wishbone slave: one wait state, unmapped reads give zero
  always_comb begin
    swen_d = swen_q;
    wb_dat_d = 32'h0000_0000;
    if (wb_cyc_i && wb_stb_i && !ack_q) begin
      if (wb_we_i && wb_adr_i == ADR_SWEN && wb_sel_i[0]) begin
        swen_d = wb_dat_i[3:0];
      end
      if (!wb_we_i && wb_adr_i == ADR_STATUS) begin
        wb_dat_d[STAT_RDY] = state_q == ST_IDLE;
        wb_dat_d[STAT_TMO] = state_q == ST_FAIL;
        wb_dat_d[STAT_SUSP] = state_q == ST_SUSP;
        wb_dat_d[STAT_WAIT] = state_q == ST_WAIT;
      end
      if (!wb_we_i && wb_adr_i == ADR_SWEN) begin
        wb_dat_d[3:0] = swen_q;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      swen_q <= SWEN_RST;
      wb_dat_q <= 32'h0000_0000;
      ack_q <= 1'b0;
    end else begin
      swen_q <= swen_d;
      wb_dat_q <= wb_dat_d;
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
    end
  end

  assign wb_dat_o = wb_dat_q;
  assign wb_ack_o = ack_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_prog_read;
    rd_i && state_q == ST_PROG && bank_hit && prog_hit;
  endsequence
  sequence s_erase_read;
    rd_i && state_q == ST_ERASE && bank_hit && in_erase_sec;
  endsequence

  property p_poll_prog;
    s_prog_read |=> rd_valid_o && rd_data_o[POS_POLL] != $past(last7);
  endproperty
  a_poll_prog: assert property (p_poll_prog) else $error("poll bit not inverted");

  property p_erase_flags;
    s_erase_read |=> !rd_data_o[POS_POLL] && !rd_data_o[POS_TMO] && rd_data_o[POS_WIN];
  endproperty
  a_erase_flags: assert property (p_erase_flags) else $error("erase flags wrong");

  property p_wait_window;
    rd_i && state_q == ST_WAIT && bank_hit && in_erase_sec
      |=> !rd_data_o[POS_WIN] && !rd_data_o[POS_POLL];
  endproperty
  a_wait_window: assert property (p_wait_window) else $error("window set in wait");

  property p_susp_toggle;
    rd_i && state_q == ST_SUSP && bank_hit && in_erase_sec
      |=> !rd_data_o[POS_TOG] && rd_data_o[POS_WIN];
  endproperty
  a_susp_toggle: assert property (p_susp_toggle) else $error("toggle runs in suspend");

  property p_toggle_run;
    s_prog_read ##1 s_prog_read |=> rd_data_o[POS_TOG] != $past(rd_data_o[POS_TOG]);
  endproperty
  a_toggle_run: assert property (p_toggle_run) else $error("toggle did not invert");

  property p_idle_data;
    rd_i && state_q == ST_IDLE |=> rd_data_o == $past(array_data_i);
  endproperty
  a_idle_data: assert property (p_idle_data) else $error("idle read not array data");

  property p_fail_timeout;
    rd_i && state_q == ST_FAIL && status_hit |=> rd_data_o[POS_TMO];
  endproperty
  a_fail_timeout: assert property (p_fail_timeout) else $error("timeout flag clear");

  property p_erase_ignore;
    state_q == ST_ERASE && cmd_valid_i && kind != CMD_SUSP |-> !cmd_accept_o;
  endproperty
  a_erase_ignore: assert property (p_erase_ignore) else $error("command taken in erase");

endmodule : flash_algorithm_status_flags

// ---- verilog/flash_flags_pkg.sv ----
// constants and types for the flash algorithm status-flag block
package flash_flags_pkg;
  // timing, in microseconds at the system clock rate
  localparam int CLK_MHZ = 100;
  localparam int PROG_TIME_US = 10;
  localparam int WAIT_TIME_US = 30;
  localparam int ERASE_TIME_US = 40;
  localparam int LIMIT_TIME_US = 40;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] PROG_CYC = CNT_W'(PROG_TIME_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] WAIT_CYC = CNT_W'(WAIT_TIME_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] ERASE_CYC = CNT_W'(ERASE_TIME_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] LIMIT_CYC = CNT_W'(LIMIT_TIME_US * CLK_MHZ);
  // status byte positions
  localparam int POS_POLL = 7;
  localparam int POS_TOG = 6;
  localparam int POS_TMO = 5;
  localparam int POS_WIN = 3;
  localparam int POS_TOG2 = 2;
  // sector start addresses; sectors 0,1 form the lower bank
  localparam logic [15:0] SEC1_BASE = 16'h1800;
  localparam logic [15:0] SEC2_BASE = 16'h2000;
  localparam logic [15:0] SEC3_BASE = 16'h8000;
  // register map (byte offsets) and fields
  localparam logic [3:0] ADR_STATUS = 4'h0;
  localparam logic [3:0] ADR_SWEN = 4'h4;
  localparam int STAT_RDY = 0;
  localparam int STAT_TMO = 1;
  localparam int STAT_SUSP = 2;
  localparam int STAT_WAIT = 3;
  localparam logic [3:0] SWEN_RST = 4'h0;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_PROG = 3'b001, ST_WAIT = 3'b011,
    ST_ERASE = 3'b010, ST_SUSP = 3'b110, ST_FAIL = 3'b111
  } state_t;
  typedef enum logic [2:0] {
    CMD_RESET = 3'h0, CMD_PROG = 3'h1, CMD_CHIP = 3'h2,
    CMD_SECT = 3'h3, CMD_SUSP = 3'h4, CMD_RESUME = 3'h5
  } cmd_t;
  function automatic logic [1:0] sector_of(input logic [15:0] a);
    if (a >= SEC3_BASE) return 2'h3;
    else if (a >= SEC2_BASE) return 2'h2;
    else if (a >= SEC1_BASE) return 2'h1;
    else return 2'h0;
  endfunction : sector_of
endpackage : flash_flags_pkg
